// ---- rtl/hmp_regs.svh ----
// Constants for the host, memory bus and strap pin block
// Operation
// R1 - First clock after reset release copies all sixteen data lines into straps
// R2 - System keeps a clock running before letting reset go inactive
// R3 - Without resistors, high byte defaults select serial EEPROM boot, bits 12,8 high
// R4 - Shared pin is upper lane enable, address bit zero, or high write strobe
// R5 - Low write strobe serves low lane or the only byte-wide memory
// R6 - Lower lane enable pin is lane enable or a port bit
// R7 - Address bits 1-18 dedicated; 19 shared with port; 20,21 with USB or ports
// R8 - Ready output in memory mode, host interrupt request in I/O mode
// R9 - Wait output asserted while a host transfer is incomplete
// R10 - Decode acknowledge tells host an I/O access was claimed
// R11 - Host selects low byte with one select, high byte with the other
// R12 - Master clock comes from a prescaler; input at least twice its rate
// R13 - Clock output selects master clock, timer clock or timer output zero
// R14 - Baseband clock divided by two and four for transceiver clocks
// R15 - High level on cable detect means a USB cable is attached
// R16 - Captured straps hold until the next reset
`ifndef HMP_REGS_SVH
`define HMP_REGS_SVH
`define HMP_STRAP_DEFAULT   16'h1100
`define HMP_WIDTH_X16       2'h0
`define HMP_WIDTH_X8        2'h1
`define HMP_WIDTH_2X8       2'h2
`define HMP_CKSEL_MCLK      2'h0
`define HMP_CKSEL_TIMER     2'h1
`define HMP_CKSEL_TMR_OUT0  2'h2
`define HMP_PRESCALE_MIN    8'h02
`define HMP_BOOT_EEPROM_HI  8'h11
`endif

// ---- rtl/hmp_pkg.sv ----
// Types for the host, memory bus and strap pin block
package hmp_pkg;
  typedef enum logic [2:0] {
    HMP_ST_RESET = 3'h1,
    HMP_ST_CAPT  = 3'h2,
    HMP_ST_RUN   = 3'h4
  } hmp_strap_t;
  typedef logic [1:0] hmp_div_t;
endpackage

// ---- rtl/hmp_clkdiv_if.sv ----
// Interface joining the baseband divider to the top
`timescale 1ns/10ps
`default_nettype none
interface hmp_clkdiv_if;
  logic div2;
  logic div4;
  modport gen (output div2, output div4);
  modport use_ (input div2, input div4);
endinterface
`default_nettype wire

// ---- rtl/hmp_bbdiv.sv ----
// Baseband clock divider producing half and quarter rate transceiver clocks
`timescale 1ns/10ps
`default_nettype none
module hmp_bbdiv
  import hmp_pkg::*;
(
  input  wire logic bb_clk,
  input  wire logic rst_n,
  hmp_clkdiv_if.gen dv
);
  hmp_div_t cnt_q;
  hmp_div_t cnt_d;

  // Two-bit counter: bit0 is divide by two, bit1 divide by four
  always_comb begin
    cnt_d = cnt_q + 2'h1; // R14
  end

  always_ff @(posedge bb_clk) begin
    if (!rst_n) begin
      cnt_q <= 2'h0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign dv.div2 = cnt_q[0];
  assign dv.div4 = cnt_q[1];

  // Quarter clock changes only when half clock falls
  a_div_ratio: assert property (@(posedge bb_clk) disable iff (!rst_n) // R14
    (cnt_q[0] && !$past(cnt_q[0])) |-> $stable(cnt_q[1]))
    else $error("quarter clock toggled off ratio");
endmodule
`default_nettype wire

// ---- rtl/hmp_top.sv ----
// Host port, memory bus pin multiplexing, clocking and strap capture
`timescale 1ns/10ps
`default_nettype none
`include "hmp_regs.svh"
module hmp_top
  import hmp_pkg::*;
(
  input  wire logic        MCLK,
  input  wire logic        RST_N,
  input  wire logic        EXT_CLOCK_IN,
  input  wire logic [7:0]  PRESCALE,
  output logic             MCLK_DIV_OUT,
  input  wire logic        TIMER_CLOCK,
  input  wire logic        TIMER_OUT_ZERO,
  input  wire logic [1:0]  CLK_SEL,
  output logic             CLOCK_OUT_PIN,
  input  wire logic        BASEBAND_CLOCK_IN,
  output logic             BB_DIV2,
  output logic             BB_DIV4,
  input  wire logic [15:0] MEMBUS_DATA_I,
  output logic [15:0]      MEMBUS_DIRECTION_REG,
  output logic [15:0]      STRAP_VALUE,
  output logic             STRAP_VALID,
  output logic             BOOT_SERIAL_EEPROM,
  input  wire logic [1:0]  MEM_WIDTH,
  input  wire logic        MEM_CYCLE,
  input  wire logic        MEM_WRITE,
  input  wire logic [1:0]  MEM_LANES,
  input  wire logic [21:0] MEM_ADDR_IN,
  output logic             MEM_UPPER_LANE_ENABLE_N,
  output logic             MEM_LOW_WRITE_STROBE_N,
  output logic             MEM_LOWER_LANE_ENABLE_N,
  output logic             MEM_LOWER_LANE_ENABLE_OE,
  input  wire logic        PORT_M_BIT2_MODE,
  input  wire logic        PORT_M_BIT2_OUT,
  output logic [18:1]      MEMBUS_ADDR,
  input  wire logic        ADDR19_ENABLE,
  input  wire logic        PORT_L_BIT4_OUT,
  input  wire logic        PORT_L_BIT4_OE,
  output logic             PORT_L_BIT4_O,
  output logic             PORT_L_BIT4_EN,
  input  wire logic        ADDR_HI_ENABLE,
  input  wire logic        USB_ACTIVE,
  input  wire logic [1:0]  PORT_L_HI_OUT,
  input  wire logic [1:0]  PORT_L_HI_OE,
  output logic [1:0]       USB_PINS_O,
  output logic [1:0]       USB_PINS_EN,
  input  wire logic        IO_MODE,
  input  wire logic        INIT_DONE,
  input  wire logic        IRQ_PENDING,
  output logic             CARD_READY_OUT,
  input  wire logic        XFER_BUSY,
  input  wire logic        IO_DECODED,
  input  wire logic        HOST_SELECT_LOW_BYTE_N,
  input  wire logic        HOST_SELECT_HIGH_BYTE_N,
  output logic             HOST_WAIT_OUT_N,
  output logic             IO_DECODE_ACK_N,
  output logic [1:0]       HOST_LANES,
  input  wire logic        USB_DETECT,
  output logic             USB_ATTACHED
);
  // ==========================================
  // Strap capture
  hmp_strap_t  st_q;
  hmp_strap_t  st_d;
  logic [15:0] strap_q;
  logic [15:0] strap_d;

  // Capture once on the first edge after reset release, then hold
  always_comb begin
    st_d    = st_q;
    strap_d = strap_q;
    case (st_q)
      HMP_ST_RESET: begin
        st_d = HMP_ST_CAPT;
      end
      HMP_ST_CAPT: begin
        strap_d = MEMBUS_DATA_I; // R1
        st_d    = HMP_ST_RUN;
      end
      HMP_ST_RUN: begin
        st_d = HMP_ST_RUN; // R16
      end
      default: begin
        st_d = HMP_ST_RESET;
      end
    endcase
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      st_q    <= HMP_ST_CAPT;
      strap_q <= `HMP_STRAP_DEFAULT; // R3
    end else begin
      st_q    <= st_d;
      strap_q <= strap_d;
    end
  end

  assign MEMBUS_DIRECTION_REG = strap_q;
  assign STRAP_VALUE          = strap_q;
  assign STRAP_VALID          = (st_q == HMP_ST_RUN);
  // Bits 12 and 8 high, rest of the high byte low, select serial EEPROM boot
  assign BOOT_SERIAL_EEPROM   = (strap_q[15:8] == `HMP_BOOT_EEPROM_HI); // R3

  a_strap_capture: assert property (@(posedge MCLK) disable iff (!RST_N) // R1
    (RST_N && st_q == HMP_ST_CAPT) |=> (strap_q == $past(MEMBUS_DATA_I)))
    else $error("strap not captured on first edge");
  a_strap_hold: assert property (@(posedge MCLK) disable iff (!RST_N) // R16
    (st_q == HMP_ST_RUN) |=> $stable(strap_q))
    else $error("strap changed after capture");

  // ==========================================
  // Master clock prescaler from external clock
  logic [2:0] ext_sync_q;
  logic [2:0] ext_sync_d;
  logic [7:0] pre_cnt_q;
  logic [7:0] pre_cnt_d;
  logic       pre_out_q;
  logic       pre_out_d;
  logic [7:0] pre_lim;

  // Ratio never below two
  assign pre_lim = (PRESCALE < `HMP_PRESCALE_MIN) ? `HMP_PRESCALE_MIN : PRESCALE; // R12

  // Count rising edges of the synchronised input, toggle each half ratio
  always_comb begin
    ext_sync_d = {ext_sync_q[1:0], EXT_CLOCK_IN};
    pre_cnt_d  = pre_cnt_q;
    pre_out_d  = pre_out_q;
    if (ext_sync_q[1] && !ext_sync_q[2]) begin
      if (pre_cnt_q >= (pre_lim >> 1) - 8'h01) begin
        pre_cnt_d = 8'h00;
        pre_out_d = !pre_out_q; // R12
      end else begin
        pre_cnt_d = pre_cnt_q + 8'h01;
      end
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      ext_sync_q <= 3'h0;
      pre_cnt_q  <= 8'h00;
      pre_out_q  <= 1'b0;
    end else begin
      ext_sync_q <= ext_sync_d;
      pre_cnt_q  <= pre_cnt_d;
      pre_out_q  <= pre_out_d;
    end
  end

  assign MCLK_DIV_OUT = pre_out_q;

  // ==========================================
  // Clock output selection and baseband divider
  logic [1:0] tsync_q [0:1];
  logic [1:0] tsync_d [0:1];
  logic       ckout_q;
  logic       ckout_d;
  logic       mclk_tgl_q;
  logic       mclk_tgl_d;

  // Timer signals resynchronised; master clock shown as half rate toggle
  always_comb begin
    tsync_d[0] = {TIMER_OUT_ZERO, TIMER_CLOCK};
    tsync_d[1] = tsync_q[0];
    mclk_tgl_d = !mclk_tgl_q;
    case (CLK_SEL)
      `HMP_CKSEL_MCLK:     ckout_d = mclk_tgl_q; // R13
      `HMP_CKSEL_TIMER:    ckout_d = tsync_q[1][0]; // R13
      `HMP_CKSEL_TMR_OUT0: ckout_d = tsync_q[1][1]; // R13
      default:             ckout_d = 1'b0;
    endcase
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      tsync_q[0] <= 2'h0;
      tsync_q[1] <= 2'h0;
      ckout_q    <= 1'b0;
      mclk_tgl_q <= 1'b0;
    end else begin
      tsync_q[0] <= tsync_d[0];
      tsync_q[1] <= tsync_d[1];
      ckout_q    <= ckout_d;
      mclk_tgl_q <= mclk_tgl_d;
    end
  end

  assign CLOCK_OUT_PIN = ckout_q;

  hmp_clkdiv_if dv ();
  hmp_bbdiv u_bbdiv (
    .bb_clk (BASEBAND_CLOCK_IN),
    .rst_n  (RST_N),
    .dv     (dv)
  );
  assign BB_DIV2 = dv.div2; // R14
  assign BB_DIV4 = dv.div4; // R14

  // ==========================================
  // Memory bus strobes and address sharing
  logic [21:0] addr_q;
  logic [21:0] addr_d;
  logic        upper_n_q;
  logic        upper_n_d;
  logic        wel_n_q;
  logic        wel_n_d;
  logic        lbe_n_q;
  logic        lbe_n_d;

  // Shared pin role follows memory width
  always_comb begin
    addr_d    = MEM_ADDR_IN;
    upper_n_d = 1'b1;
    wel_n_d   = 1'b1;
    lbe_n_d   = 1'b1;
    if (MEM_CYCLE) begin
      case (MEM_WIDTH)
        `HMP_WIDTH_X16: begin
          upper_n_d = !MEM_LANES[1]; // R4
          lbe_n_d   = !MEM_LANES[0]; // R6
          wel_n_d   = !(MEM_WRITE && (MEM_LANES != 2'h0)); // R5
        end
        `HMP_WIDTH_X8: begin
          upper_n_d = MEM_ADDR_IN[0]; // R4
          wel_n_d   = !MEM_WRITE; // R5
          lbe_n_d   = 1'b0;
        end
        `HMP_WIDTH_2X8: begin
          upper_n_d = !(MEM_WRITE && MEM_LANES[1]); // R4
          wel_n_d   = !(MEM_WRITE && MEM_LANES[0]); // R5
          lbe_n_d   = !MEM_LANES[0];
        end
        default: begin
          upper_n_d = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      addr_q    <= 22'h000000;
      upper_n_q <= 1'b1;
      wel_n_q   <= 1'b1;
      lbe_n_q   <= 1'b1;
    end else begin
      addr_q    <= addr_d;
      upper_n_q <= upper_n_d;
      wel_n_q   <= wel_n_d;
      lbe_n_q   <= lbe_n_d;
    end
  end

  assign MEM_UPPER_LANE_ENABLE_N  = upper_n_q;
  assign MEM_LOW_WRITE_STROBE_N   = wel_n_q;
  // Lower lane pin becomes a port bit when PORT_M_BIT2_MODE is set
  assign MEM_LOWER_LANE_ENABLE_N  = PORT_M_BIT2_MODE ? PORT_M_BIT2_OUT : lbe_n_q; // R6
  assign MEM_LOWER_LANE_ENABLE_OE = 1'b1;
  assign MEMBUS_ADDR              = addr_q[18:1]; // R7
  assign PORT_L_BIT4_O            = ADDR19_ENABLE ? addr_q[19] : PORT_L_BIT4_OUT; // R7
  assign PORT_L_BIT4_EN           = ADDR19_ENABLE | PORT_L_BIT4_OE; // R7
  // USB pins carry high address, the transceiver, or port bits
  assign USB_PINS_O  = ADDR_HI_ENABLE ? addr_q[21:20] : PORT_L_HI_OUT; // R7
  assign USB_PINS_EN = USB_ACTIVE ? 2'h0 : (ADDR_HI_ENABLE ? 2'h3 : PORT_L_HI_OE); // R7

  a_x16_upper: assert property (@(posedge MCLK) disable iff (!RST_N) // R4
    (RST_N && MEM_CYCLE && MEM_WIDTH == `HMP_WIDTH_X16) |=> (upper_n_q == !$past(MEM_LANES[1])))
    else $error("upper lane enable wrong for x16");
  a_low_strobe: assert property (@(posedge MCLK) disable iff (!RST_N) // R5
    (!MEM_CYCLE || !MEM_WRITE) |=> wel_n_q)
    else $error("low write strobe without write");

  // ==========================================
  // Host port handshake outputs
  logic [1:0] usb_sync_q;
  logic [1:0] usb_sync_d;
  logic       rdy_q;
  logic       rdy_d;
  logic       wait_n_q;
  logic       wait_n_d;
  logic       ack_n_q;
  logic       ack_n_d;

  // Ready or interrupt by mode; wait from transfer state, decode ack from the decode flag
  always_comb begin
    usb_sync_d = {usb_sync_q[0], USB_DETECT};
    rdy_d      = IO_MODE ? IRQ_PENDING : INIT_DONE; // R8
    wait_n_d   = !XFER_BUSY; // R9
    ack_n_d    = !IO_DECODED; // R10
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      usb_sync_q <= 2'h0;
      rdy_q      <= 1'b0;
      wait_n_q   <= 1'b1;
      ack_n_q    <= 1'b1;
    end else begin
      usb_sync_q <= usb_sync_d;
      rdy_q      <= rdy_d;
      wait_n_q   <= wait_n_d;
      ack_n_q    <= ack_n_d;
    end
  end

  // Interrupt request is low active in I/O mode
  assign CARD_READY_OUT  = IO_MODE ? !rdy_q : rdy_q; // R8
  assign HOST_WAIT_OUT_N = wait_n_q;
  assign IO_DECODE_ACK_N = ack_n_q;
  assign HOST_LANES      = {!HOST_SELECT_HIGH_BYTE_N, !HOST_SELECT_LOW_BYTE_N}; // R11
  assign USB_ATTACHED    = usb_sync_q[1]; // R15

  a_wait_busy: assert property (@(posedge MCLK) disable iff (!RST_N) // R9
    (RST_N && XFER_BUSY) |=> !HOST_WAIT_OUT_N)
    else $error("wait not asserted while busy");
  a_ack_decode: assert property (@(posedge MCLK) disable iff (!RST_N) // R10
    (RST_N && IO_DECODED) |=> !IO_DECODE_ACK_N)
    else $error("decode ack missing");
  a_ready_memmode: assert property (@(posedge MCLK) disable iff (!RST_N) // R8
    (RST_N && !IO_MODE && INIT_DONE) ##1 !IO_MODE |-> CARD_READY_OUT)
    else $error("ready not shown after init");
  a_usb_detect: assert property (@(posedge MCLK) disable iff (!RST_N) // R15
    USB_DETECT [*3] |-> USB_ATTACHED)
    else $error("cable attach not seen");
endmodule
`default_nettype wire

// ---- verif/hmp_far_model.sv ----
// Far side model: system clocks, strap resistors and memory data lines
`timescale 1ns/10ps
`default_nettype none
module hmp_far_model (
  input  wire logic        mclk,
  input  wire logic        fit,
  input  wire logic [15:0] val,
  input  wire logic        busy,
  output logic             ext_clk,
  output logic             tmr_clk,
  output logic             tmr_out0,
  output logic             bb_clk,
  output logic [15:0]      mem_data
);
  logic [15:0] pat_q;
  // ==========
  // Clocks run from time zero, ahead of any reset release
  initial begin
    {ext_clk, tmr_clk, tmr_out0, bb_clk} = 4'h0;
    pat_q = 16'h5a3c;
  end
  always #50 ext_clk = ~ext_clk;
  always #200 tmr_clk = ~tmr_clk;
  always #400 tmr_out0 = ~tmr_out0;
  always #11.36 bb_clk = ~bb_clk;
  // ==========
  // Memories drive a pattern that changes every cycle once busy
  always @(posedge mclk) begin
    pat_q <= ~{pat_q[14:0], pat_q[15]};
  end
  // Without resistors the internal pulls set the strap levels
  assign mem_data = busy ? pat_q : (fit ? val : 16'h11ff);
endmodule
`default_nettype wire

// ---- verif/hmp_top_tb.sv ----
// Self-checking bench for the host, memory bus and strap pin block
`timescale 1ns/10ps
`default_nettype none
module hmp_top_tb;
  import hmp_pkg::*;
  typedef struct {int unsigned id; logic [17:0] exp; int unsigned due;} hmp_note_t;
  logic        MCLK, RST_N, EXT_CLOCK_IN, MCLK_DIV_OUT, TIMER_CLOCK, TIMER_OUT_ZERO, CLOCK_OUT_PIN, BASEBAND_CLOCK_IN;
  logic        BB_DIV2, BB_DIV4, STRAP_VALID, BOOT_SERIAL_EEPROM, MEM_CYCLE, MEM_WRITE, MEM_UPPER_LANE_ENABLE_N;
  logic        MEM_LOW_WRITE_STROBE_N, MEM_LOWER_LANE_ENABLE_N, MEM_LOWER_LANE_ENABLE_OE, PORT_M_BIT2_MODE;
  logic        PORT_M_BIT2_OUT, ADDR19_ENABLE, PORT_L_BIT4_OUT, PORT_L_BIT4_OE, PORT_L_BIT4_O, PORT_L_BIT4_EN;
  logic        ADDR_HI_ENABLE, USB_ACTIVE, IO_MODE, INIT_DONE, IRQ_PENDING, CARD_READY_OUT, XFER_BUSY, IO_DECODED;
  logic        HOST_SELECT_LOW_BYTE_N, HOST_SELECT_HIGH_BYTE_N, HOST_WAIT_OUT_N, IO_DECODE_ACK_N, USB_DETECT;
  logic        USB_ATTACHED, strap_fit, bus_busy;
  logic [1:0]  CLK_SEL, MEM_WIDTH, MEM_LANES, PORT_L_HI_OUT, PORT_L_HI_OE, USB_PINS_O, USB_PINS_EN, HOST_LANES;
  logic [7:0]  PRESCALE;
  logic [15:0] MEMBUS_DATA_I, MEMBUS_DIRECTION_REG, STRAP_VALUE, strap_val;
  logic [18:1] MEMBUS_ADDR;
  logic [21:0] MEM_ADDR_IN;
  int unsigned cyc, n_errors, tests_run, c0, c1, n_co, n_mdiv, n_b2, n_b4;
  hmp_note_t   notes[$];
  hmp_note_t   nt;
  string       names[13] = '{"strap", "boot", "upper", "wel", "lower", "addr", "wait", "ack", "ready", "lanes",
                             "pins", "dir", "enables"};
  int unsigned exp_co[4] = '{64, 8, 4, 0};
  logic [7:0]  pre[3] = '{8'h04, 8'h01, 8'h08};
  int unsigned exp_mdiv[3] = '{20, 40, 10};

  hmp_top hmp_top_inst (.MCLK(MCLK), .RST_N(RST_N), .EXT_CLOCK_IN(EXT_CLOCK_IN), .PRESCALE(PRESCALE),
    .MCLK_DIV_OUT(MCLK_DIV_OUT), .TIMER_CLOCK(TIMER_CLOCK), .TIMER_OUT_ZERO(TIMER_OUT_ZERO), .CLK_SEL(CLK_SEL),
    .CLOCK_OUT_PIN(CLOCK_OUT_PIN), .BASEBAND_CLOCK_IN(BASEBAND_CLOCK_IN), .BB_DIV2(BB_DIV2), .BB_DIV4(BB_DIV4),
    .MEMBUS_DATA_I(MEMBUS_DATA_I), .MEMBUS_DIRECTION_REG(MEMBUS_DIRECTION_REG), .STRAP_VALUE(STRAP_VALUE),
    .STRAP_VALID(STRAP_VALID), .BOOT_SERIAL_EEPROM(BOOT_SERIAL_EEPROM), .MEM_WIDTH(MEM_WIDTH),
    .MEM_CYCLE(MEM_CYCLE), .MEM_WRITE(MEM_WRITE), .MEM_LANES(MEM_LANES), .MEM_ADDR_IN(MEM_ADDR_IN),
    .MEM_UPPER_LANE_ENABLE_N(MEM_UPPER_LANE_ENABLE_N), .MEM_LOW_WRITE_STROBE_N(MEM_LOW_WRITE_STROBE_N),
    .MEM_LOWER_LANE_ENABLE_N(MEM_LOWER_LANE_ENABLE_N), .MEM_LOWER_LANE_ENABLE_OE(MEM_LOWER_LANE_ENABLE_OE),
    .PORT_M_BIT2_MODE(PORT_M_BIT2_MODE), .PORT_M_BIT2_OUT(PORT_M_BIT2_OUT), .MEMBUS_ADDR(MEMBUS_ADDR),
    .ADDR19_ENABLE(ADDR19_ENABLE), .PORT_L_BIT4_OUT(PORT_L_BIT4_OUT), .PORT_L_BIT4_OE(PORT_L_BIT4_OE),
    .PORT_L_BIT4_O(PORT_L_BIT4_O), .PORT_L_BIT4_EN(PORT_L_BIT4_EN), .ADDR_HI_ENABLE(ADDR_HI_ENABLE),
    .USB_ACTIVE(USB_ACTIVE), .PORT_L_HI_OUT(PORT_L_HI_OUT), .PORT_L_HI_OE(PORT_L_HI_OE), .USB_PINS_O(USB_PINS_O),
    .USB_PINS_EN(USB_PINS_EN), .IO_MODE(IO_MODE), .INIT_DONE(INIT_DONE), .IRQ_PENDING(IRQ_PENDING),
    .CARD_READY_OUT(CARD_READY_OUT), .XFER_BUSY(XFER_BUSY), .IO_DECODED(IO_DECODED),
    .HOST_SELECT_LOW_BYTE_N(HOST_SELECT_LOW_BYTE_N), .HOST_SELECT_HIGH_BYTE_N(HOST_SELECT_HIGH_BYTE_N),
    .HOST_WAIT_OUT_N(HOST_WAIT_OUT_N), .IO_DECODE_ACK_N(IO_DECODE_ACK_N), .HOST_LANES(HOST_LANES),
    .USB_DETECT(USB_DETECT), .USB_ATTACHED(USB_ATTACHED));
  hmp_far_model hmp_far_model_inst (.mclk(MCLK), .fit(strap_fit), .val(strap_val), .busy(bus_busy),
    .ext_clk(EXT_CLOCK_IN), .tmr_clk(TIMER_CLOCK), .tmr_out0(TIMER_OUT_ZERO), .bb_clk(BASEBAND_CLOCK_IN),
    .mem_data(MEMBUS_DATA_I));

  // ==========
  // Clock, cycle count and hang guard
  always #12.5 MCLK = ~MCLK;
  always @(posedge MCLK) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      n_errors++;
      stop_test();
    end
  end
  // Edge counters for the clock outputs
  always @(CLOCK_OUT_PIN) n_co++;
  always @(MCLK_DIV_OUT) n_mdiv++;
  always @(posedge BB_DIV2) n_b2++;
  always @(posedge BB_DIV4) n_b4++;

  // ==========
  // Comparison, notes and closing
  task automatic check(string nm, logic [17:0] seen, logic [17:0] e);
    tests_run++;
    if (seen !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, seen);
    end
  endtask
  task automatic tol(string nm, int unsigned seen, int unsigned e);
    check(nm, {17'h0, (seen + 1 >= e) && (seen <= e + 1)}, 18'h1);
  endtask
  task automatic note(int unsigned id, logic [17:0] e, int unsigned lat);
    notes.push_back('{id, e, cyc + lat});
  endtask
  task automatic tick(int unsigned n);
    repeat (n) @(posedge MCLK);
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  function automatic logic [17:0] obs(int unsigned id);
    case (id)
      0: obs = {2'h0, STRAP_VALUE};
      1: obs = {17'h0, BOOT_SERIAL_EEPROM};
      2: obs = {17'h0, MEM_UPPER_LANE_ENABLE_N};
      3: obs = {17'h0, MEM_LOW_WRITE_STROBE_N};
      4: obs = {17'h0, MEM_LOWER_LANE_ENABLE_N};
      5: obs = MEMBUS_ADDR;
      6: obs = {17'h0, HOST_WAIT_OUT_N};
      7: obs = {17'h0, IO_DECODE_ACK_N};
      8: obs = {17'h0, CARD_READY_OUT};
      9: obs = {16'h0, HOST_LANES};
      10: obs = {15'h0, USB_PINS_O, PORT_L_BIT4_O};
      12: obs = {14'h0, MEM_LOWER_LANE_ENABLE_OE, USB_PINS_EN, PORT_L_BIT4_EN};
      default: obs = {2'h0, MEMBUS_DIRECTION_REG};
    endcase
  endfunction
  // Monitor takes due notes off the queue and compares
  always @(negedge MCLK) begin
    while (notes.size() > 0 && notes[0].due <= cyc) begin
      nt = notes.pop_front();
      check(names[nt.id], obs(nt.id), nt.exp);
    end
  end

  // ==========
  // Reset with given strap levels, then bus activity afterwards
  task automatic strap(logic fit, logic [15:0] v);
    logic [15:0] e;
    e = fit ? v : 16'h11ff;
    @(posedge MCLK);
    {strap_fit, strap_val, bus_busy, RST_N} <= {fit, v, 2'b00};
    tick(5);
    RST_N <= 1'b1;
    note(0, 18'h1100, 0);
    note(0, {2'h0, e}, 2);
    note(11, {2'h0, e}, 2);
    note(1, {17'h0, e[15:8] == 8'h11}, 2);
    tick(2);
    bus_busy <= 1'b1;
    check("strap valid", {17'h0, STRAP_VALID}, 18'h1);
    tick(6);
    note(0, {2'h0, e}, 0);
    tick(2);
    $display("test strap done");
  endtask
  // One memory cycle followed by one idle cycle
  task automatic mem(logic [1:0] w, logic wr, logic [1:0] ln, logic eu, logic ewl);
    logic [21:0] a;
    a = 22'($urandom);
    @(posedge MCLK);
    {MEM_WIDTH, MEM_WRITE, MEM_LANES, MEM_ADDR_IN, MEM_CYCLE} <= {w, wr, ln, a, 1'b1};
    note(2, {17'h0, (w == 2'h1) ? a[0] : eu}, 2);
    note(3, {17'h0, ewl}, 2);
    if (w == 2'h0) note(4, {17'h0, !ln[0]}, 2);
    note(5, 18'(a[18:1]), 2);
    note(10, {15'h0, a[21:19]}, 3);
    note(12, 18'hf, 3);
    @(posedge MCLK);
    MEM_CYCLE <= 1'b0;
    note(3, 18'h1, 2);
  endtask

  // ==========
  // Main sequence
  initial begin
    MCLK = 1'b0;
    {RST_N, MEM_CYCLE, MEM_WRITE, MEM_WIDTH, MEM_LANES, MEM_ADDR_IN, PORT_M_BIT2_MODE, PORT_M_BIT2_OUT} = '0;
    {PORT_L_BIT4_OUT, PORT_L_BIT4_OE, USB_ACTIVE, PORT_L_HI_OUT, PORT_L_HI_OE, IO_MODE, INIT_DONE} = '0;
    {IRQ_PENDING, XFER_BUSY, IO_DECODED, USB_DETECT, CLK_SEL, strap_fit, bus_busy, strap_val} = '0;
    {ADDR19_ENABLE, ADDR_HI_ENABLE, HOST_SELECT_LOW_BYTE_N, HOST_SELECT_HIGH_BYTE_N} = 4'hf;
    PRESCALE = 8'h04;
    void'($urandom(30));
    strap(1'b0, 16'h0000);
    strap(1'b1, 16'($urandom));
    // Every combination of host side levels, back to back
    for (int i = 0; i < 128; i++) begin
      @(posedge MCLK);
      {IO_MODE, INIT_DONE, IRQ_PENDING, XFER_BUSY, IO_DECODED, HOST_SELECT_HIGH_BYTE_N,
       HOST_SELECT_LOW_BYTE_N} <= 7'(i);
      note(9, {16'h0, !i[1], !i[0]}, 1);
      note(6, {17'h0, !i[3]}, 2);
      note(7, {17'h0, !i[2]}, 2);
      if (i[5:0] != 6'h3f) note(8, {17'h0, i[6] ? !i[4] : i[5]}, 2);
    end
    $display("test host done");
    mem(2'h0, 1'b1, 2'b01, 1'b1, 1'b0);
    mem(2'h0, 1'b0, 2'b11, 1'b0, 1'b1);
    mem(2'h1, 1'b1, 2'b01, 1'b0, 1'b0);
    mem(2'h2, 1'b1, 2'b10, 1'b0, 1'b1);
    mem(2'h2, 1'b1, 2'b01, 1'b1, 1'b0);
    tick(3);
    $display("test membus done");
    // Shared pins handed over to the port bits
    {PORT_M_BIT2_MODE, PORT_M_BIT2_OUT, ADDR19_ENABLE, ADDR_HI_ENABLE, PORT_L_BIT4_OUT, PORT_L_HI_OUT} <= 7'h46;
    note(4, 18'h0, 1);
    note(10, 18'h5, 3);
    note(12, 18'h8, 3);
    tick(4);
    {PORT_M_BIT2_MODE, ADDR19_ENABLE, ADDR_HI_ENABLE} <= 3'h3;
    USB_ACTIVE <= 1'b1;
    note(12, 18'h9, 1);
    USB_DETECT <= 1'b1;
    c0 = 0;
    while (USB_ATTACHED !== 1'b1 && c0 < 6) begin
      @(posedge MCLK);
      c0++;
    end
    check("usb attached", {17'h0, USB_ATTACHED}, 18'h1);
    $display("test pins done");
    // Clock output selection, prescaler ratios and baseband division
    for (int s = 0; s < 4; s++) begin
      CLK_SEL <= 2'(s);
      tick(8);
      c0 = n_co;
      tick(64);
      tol("clock out toggles", n_co - c0, exp_co[s]);
    end
    for (int k = 0; k < 3; k++) begin
      PRESCALE <= pre[k];
      tick(12);
      c0 = n_mdiv;
      tick(160);
      tol("prescaler toggles", n_mdiv - c0, exp_mdiv[k]);
    end
    c0 = n_b2;
    c1 = n_b4;
    repeat (16) @(posedge BASEBAND_CLOCK_IN);
    tol("div2 rises", n_b2 - c0, 8);
    tol("div4 rises", n_b4 - c1, 4);
    $display("test clocks done");
    stop_test();
  end
endmodule
`default_nettype wire
